// ==== verilog/pjk_map.vh ====
`ifndef PJK_MAP_VH
`define PJK_MAP_VH

// register indices on the plain register port
`define PJK_ADDR_W 4
`define PJK_OFS_PORT_J 4'h0
`define PJK_OFS_DIR_J 4'h1
`define PJK_OFS_PIN_J 4'h2
`define PJK_OFS_PORT_K 4'h3
`define PJK_OFS_DIR_K 4'h4
`define PJK_OFS_PIN_K 4'h5
`define PJK_OFS_CTRL 4'h6
`define PJK_OFS_MASK_J 4'h7
`define PJK_OFS_MASK_K 4'h8

// control register fields
`define PJK_CTRL_PUD 0
`define PJK_CTRL_GRP1 1
`define PJK_CTRL_GRP2 2
`define PJK_CTRL_MASK 8'h07

// first port mask: bit n is pin-change source 8+n, bit 0 unused
`define PJK_MASK_J_MASK 8'hFE

// reset values
`define PJK_RST_PORT 8'h00
`define PJK_RST_DIR 8'h00
`define PJK_RST_CTRL 8'h00
`define PJK_RST_MASK 8'h00

// pin numbers with serial roles on the first port
`define PJK_PIN_RX 0
`define PJK_PIN_TX 1
`define PJK_PIN_XCK 2

`endif

// ==== verilog/pjk_sync.v ====
// three-stage pin synchroniser with agreement filter
module pjk_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire nrst,
  input wire ce,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg filt_q;
      always @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          filt_q <= 1'b0;
        end
        else if (ce)
        begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // only a settled level is taken
          if (s2_q == s3_q)
            filt_q <= s3_q;
        end
      end
      assign pin_q[i] = filt_q;
    end
  endgenerate

endmodule // pjk_sync

// ==== verilog/pjk_altfn.v ====
// Chosen here: the address-and-strobe port and the register addresses.
`include "pjk_map.vh"

module pjk_altfn #(
  parameter PORT_W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire ce,
  input wire [`PJK_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire serial3_rx_enable,
  input wire serial3_tx_enable,
  input wire serial3_tx_line,
  input wire serial3_sync_mode,
  input wire serial3_ext_clock,
  input wire sleep_input_disable,
  input wire [PORT_W-1:0] pj_pin_in,
  output reg [PORT_W-1:0] pj_pin_out,
  output reg [PORT_W-1:0] pj_pin_oe_n,
  output reg [PORT_W-1:0] pj_pullup_en,
  input wire [PORT_W-1:0] pk_pin_in,
  output reg [PORT_W-1:0] pk_pin_out,
  output reg [PORT_W-1:0] pk_pin_oe_n,
  output reg [PORT_W-1:0] pk_pullup_en,
  output reg serial3_rx_line,
  output reg serial3_ext_clock_in,
  output reg [3:0] pin_change_src_15_12,
  output reg pin_change_src_11,
  output reg pin_change_src_10,
  output reg pin_change_src_9,
  output reg [7:0] pin_change_src_23_16,
  output reg [7:0] converter_channels_15_8
);

  localparam NPIN = 2 * PORT_W;

  // software-visible state
  reg [7:0] port_j_q;
  reg [7:0] dir_j_q;
  reg [7:0] port_k_q;
  reg [7:0] dir_k_q;
  reg [7:0] ctrl_q;
  reg [7:0] mask_j_q;
  reg [7:0] mask_k_q;
  reg [7:0] rdata_d;

  wire global_pullup_disable;
  wire pin_change_group1_enable;
  wire pin_change_group2_enable;
  wire first_port_dir_bit2;
  wire first_port_dir_bit0;
  wire first_port_data_bit0;

  assign global_pullup_disable = ctrl_q[`PJK_CTRL_PUD];
  assign pin_change_group1_enable = ctrl_q[`PJK_CTRL_GRP1];
  assign pin_change_group2_enable = ctrl_q[`PJK_CTRL_GRP2];
  assign first_port_dir_bit2 = dir_j_q[`PJK_PIN_XCK];
  assign first_port_dir_bit0 = dir_j_q[`PJK_PIN_RX];
  assign first_port_data_bit0 = port_j_q[`PJK_PIN_RX];

  // synchronised pin levels
  wire [PORT_W-1:0] pj_sync;
  wire [PORT_W-1:0] pk_sync;

  pjk_sync #(
    .WIDTH(PORT_W)
  ) u_sync_j (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .pin_in(pj_pin_in),
    .pin_q(pj_sync)
  );

  pjk_sync #(
    .WIDTH(PORT_W)
  ) u_sync_k (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .pin_in(pk_pin_in),
    .pin_q(pk_sync)
  );

  // register writes
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_j_q <= `PJK_RST_PORT;
      dir_j_q <= `PJK_RST_DIR;
      port_k_q <= `PJK_RST_PORT;
      dir_k_q <= `PJK_RST_DIR;
      ctrl_q <= `PJK_RST_CTRL;
      mask_j_q <= `PJK_RST_MASK;
      mask_k_q <= `PJK_RST_MASK;
    end
    else if (ce && reg_wr)
    begin
      case (reg_addr)
        `PJK_OFS_PORT_J: port_j_q <= reg_wdata;
        `PJK_OFS_DIR_J: dir_j_q <= reg_wdata;
        `PJK_OFS_PORT_K: port_k_q <= reg_wdata;
        `PJK_OFS_DIR_K: dir_k_q <= reg_wdata;
        `PJK_OFS_CTRL: ctrl_q <= reg_wdata & `PJK_CTRL_MASK;
        `PJK_OFS_MASK_J: mask_j_q <= reg_wdata & `PJK_MASK_J_MASK;
        `PJK_OFS_MASK_K: mask_k_q <= reg_wdata;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // first port override terms
  reg serial3_ext_clock_active;
  reg xck_out_active;
  reg [7:0] j_pullup_override_enable;
  reg [7:0] j_pullup_override_value;
  reg [7:0] j_direction_override_enable;
  reg [7:0] j_direction_override_value;
  reg [7:0] j_port_value_override_enable;
  reg [7:0] j_port_value_override_value;
  reg [7:0] j_input_enable_override_enable;
  reg [7:0] j_input_enable_override_value;

  always @*
  begin
    // clock pin only lives in synchronous mode
    serial3_ext_clock_active = serial3_sync_mode;
    // direction bit decides clock output versus input
    xck_out_active = serial3_ext_clock_active & first_port_dir_bit2;
    j_pullup_override_enable = 8'h00;
    j_pullup_override_value = 8'h00;
    j_direction_override_enable = 8'h00;
    j_direction_override_value = 8'h00;
    j_port_value_override_enable = 8'h00;
    j_port_value_override_value = 8'h00;
    j_input_enable_override_enable = 8'h00;
    j_input_enable_override_value = 8'h00;
    // receive pin: input, pull-up follows data bit
    j_pullup_override_enable[`PJK_PIN_RX] = serial3_rx_enable;
    j_pullup_override_value[`PJK_PIN_RX] = first_port_data_bit0 & ~global_pullup_disable;
    j_direction_override_enable[`PJK_PIN_RX] = serial3_rx_enable;
    j_direction_override_value[`PJK_PIN_RX] = 1'b0;
    j_port_value_override_enable[`PJK_PIN_RX] = 1'b0;
    j_port_value_override_value[`PJK_PIN_RX] = 1'b0;
    // transmit pin: output driven by transmitter
    j_pullup_override_enable[`PJK_PIN_TX] = serial3_tx_enable;
    j_pullup_override_value[`PJK_PIN_TX] = 1'b0;
    j_direction_override_enable[`PJK_PIN_TX] = serial3_tx_enable;
    j_direction_override_value[`PJK_PIN_TX] = 1'b1;
    j_port_value_override_enable[`PJK_PIN_TX] = serial3_tx_enable;
    j_port_value_override_value[`PJK_PIN_TX] = serial3_tx_line;
    // clock pin: output carries serial clock
    j_direction_override_enable[`PJK_PIN_XCK] = xck_out_active;
    j_direction_override_value[`PJK_PIN_XCK] = 1'b1;
    j_port_value_override_enable[`PJK_PIN_XCK] = xck_out_active;
    j_port_value_override_value[`PJK_PIN_XCK] = serial3_ext_clock;
    // sensing-only pins keep pull-up, direction and value from registers
    j_pullup_override_enable[6:4] = 3'h0;
    j_pullup_override_value[6:4] = 3'h0;
    j_direction_override_enable[6:4] = 3'h0;
    j_direction_override_value[6:4] = 3'h0;
    j_port_value_override_enable[6:4] = 3'h0;
    j_port_value_override_value[6:4] = 3'h0;
    // input enable forced on while pin-change sensing is armed
    j_input_enable_override_enable[6:4] = mask_j_q[7:5] & {3{pin_change_group1_enable}};
    j_input_enable_override_value[6:4] = 3'h7;
    j_input_enable_override_enable[3:0] = mask_j_q[4:1] & {4{pin_change_group1_enable}};
    j_input_enable_override_value[3:0] = 4'hF;
    // pin 7 keeps all enables at zero
    j_pullup_override_enable[7] = 1'h0;
    j_pullup_override_value[7] = 1'h0;
    j_direction_override_enable[7] = 1'h0;
    j_direction_override_value[7] = 1'h0;
    j_port_value_override_enable[7] = 1'h0;
    j_port_value_override_value[7] = 1'h0;
    j_input_enable_override_enable[7] = 1'h0;
    j_input_enable_override_value[7] = 1'h0;
  end

  // second port override terms
  wire [7:0] k_zero;
  wire [7:0] k_input_enable_override_enable;
  wire [7:0] k_input_enable_override_value;

  assign k_zero = 8'h00;
  assign k_input_enable_override_enable = mask_k_q & {8{pin_change_group2_enable}};
  assign k_input_enable_override_value = 8'hFF;

  // both ports as one pin vector, second port in the upper half
  wire [NPIN-1:0] all_port;
  wire [NPIN-1:0] all_dir;
  wire [NPIN-1:0] all_sync;
  wire [NPIN-1:0] all_pullup_override_enable;
  wire [NPIN-1:0] all_pullup_override_value;
  wire [NPIN-1:0] all_direction_override_enable;
  wire [NPIN-1:0] all_direction_override_value;
  wire [NPIN-1:0] all_port_value_override_enable;
  wire [NPIN-1:0] all_port_value_override_value;
  wire [NPIN-1:0] all_input_enable_override_enable;
  wire [NPIN-1:0] all_input_enable_override_value;

  assign all_port = {port_k_q[PORT_W-1:0], port_j_q[PORT_W-1:0]};
  assign all_dir = {dir_k_q[PORT_W-1:0], dir_j_q[PORT_W-1:0]};
  assign all_sync = {pk_sync, pj_sync};
  assign all_pullup_override_enable = {k_zero[PORT_W-1:0], j_pullup_override_enable[PORT_W-1:0]};
  assign all_pullup_override_value = {k_zero[PORT_W-1:0], j_pullup_override_value[PORT_W-1:0]};
  assign all_direction_override_enable = {k_zero[PORT_W-1:0], j_direction_override_enable[PORT_W-1:0]};
  assign all_direction_override_value = {k_zero[PORT_W-1:0], j_direction_override_value[PORT_W-1:0]};
  assign all_port_value_override_enable = {k_zero[PORT_W-1:0], j_port_value_override_enable[PORT_W-1:0]};
  assign all_port_value_override_value = {k_zero[PORT_W-1:0], j_port_value_override_value[PORT_W-1:0]};
  assign all_input_enable_override_enable = {k_input_enable_override_enable[PORT_W-1:0], j_input_enable_override_enable[PORT_W-1:0]};
  assign all_input_enable_override_value = {k_input_enable_override_value[PORT_W-1:0], j_input_enable_override_value[PORT_W-1:0]};

  // per-pin merge of register control and overrides
  wire [NPIN-1:0] fin_pullup;
  wire [NPIN-1:0] fin_dir;
  wire [NPIN-1:0] fin_out;
  wire [NPIN-1:0] fin_die;
  wire [NPIN-1:0] fin_di;

  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1)
    begin : g_pin
      wire reg_pullup;
      wire reg_die;
      // pull-up from registers: input with data bit set
      assign reg_pullup = ~all_dir[p] & all_port[p];
      assign reg_die = ~sleep_input_disable;
      assign fin_pullup[p] = (all_pullup_override_enable[p] ? all_pullup_override_value[p] : reg_pullup) & ~global_pullup_disable;
      assign fin_dir[p] = all_direction_override_enable[p] ? all_direction_override_value[p] : all_dir[p];
      assign fin_out[p] = all_port_value_override_enable[p] ? all_port_value_override_value[p] : all_port[p];
      assign fin_die[p] = all_input_enable_override_enable[p] ? all_input_enable_override_value[p] : reg_die;
      // disabled digital input reads low
      assign fin_di[p] = all_sync[p] & fin_die[p];
    end
  endgenerate

  // registered pin controls
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pj_pin_out <= {PORT_W{1'b0}};
      pj_pin_oe_n <= {PORT_W{1'b1}};
      pj_pullup_en <= {PORT_W{1'b0}};
      pk_pin_out <= {PORT_W{1'b0}};
      pk_pin_oe_n <= {PORT_W{1'b1}};
      pk_pullup_en <= {PORT_W{1'b0}};
    end
    else if (ce)
    begin
      pj_pin_out <= fin_out[PORT_W-1:0];
      pj_pin_oe_n <= ~fin_dir[PORT_W-1:0];
      pj_pullup_en <= fin_pullup[PORT_W-1:0];
      pk_pin_out <= fin_out[NPIN-1:PORT_W];
      pk_pin_oe_n <= ~fin_dir[NPIN-1:PORT_W];
      pk_pullup_en <= fin_pullup[NPIN-1:PORT_W];
    end
  end

  // digital inputs toward peripherals
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial3_rx_line <= 1'b0;
      serial3_ext_clock_in <= 1'b0;
      pin_change_src_15_12 <= 4'h0;
      pin_change_src_11 <= 1'b0;
      pin_change_src_10 <= 1'b0;
      pin_change_src_9 <= 1'b0;
      pin_change_src_23_16 <= 8'h00;
      converter_channels_15_8 <= 8'h00;
    end
    else if (ce)
    begin
      pin_change_src_15_12 <= fin_di[6:3];
      pin_change_src_11 <= fin_di[`PJK_PIN_XCK];
      pin_change_src_10 <= fin_di[`PJK_PIN_TX];
      pin_change_src_9 <= fin_di[`PJK_PIN_RX];
      serial3_rx_line <= fin_di[`PJK_PIN_RX];
      // clock input only in synchronous mode
      serial3_ext_clock_in <= fin_di[`PJK_PIN_XCK] & serial3_ext_clock_active;
      pin_change_src_23_16 <= fin_di[PORT_W+7:PORT_W];
      // analog path bypasses the input enable gate
      converter_channels_15_8 <= pk_sync[7:0];
    end
  end

  // register reads, data one cycle after strobe
  always @*
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      `PJK_OFS_PORT_J: rdata_d = port_j_q;
      `PJK_OFS_DIR_J: rdata_d = dir_j_q;
      `PJK_OFS_PIN_J: rdata_d = fin_di[7:0];
      `PJK_OFS_PORT_K: rdata_d = port_k_q;
      `PJK_OFS_DIR_K: rdata_d = dir_k_q;
      `PJK_OFS_PIN_K: rdata_d = fin_di[PORT_W+7:PORT_W];
      `PJK_OFS_CTRL: rdata_d = ctrl_q;
      `PJK_OFS_MASK_J: rdata_d = mask_j_q;
      `PJK_OFS_MASK_K: rdata_d = mask_k_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (ce)
    begin
      if (reg_rd)
        reg_rdata <= rdata_d;
      else
        reg_rdata <= 8'h00;
    end
  end

endmodule // pjk_altfn

// ==== tb/pjk_altfn_props.sv ====
module pjk_altfn_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic serial3_rx_enable,
  input wire logic serial3_tx_enable,
  input wire logic serial3_tx_line,
  input wire logic serial3_sync_mode,
  input wire logic serial3_ext_clock,
  input wire logic sleep_input_disable,
  input wire logic [7:0] pj_pin_in,
  input wire logic [7:0] pj_pin_out,
  input wire logic [7:0] pj_pin_oe_n,
  input wire logic [7:0] pj_pullup_en,
  input wire logic [7:0] pk_pin_in,
  input wire logic serial3_rx_line,
  input wire logic serial3_ext_clock_in,
  input wire logic [3:0] pin_change_src_15_12,
  input wire logic pin_change_src_11,
  input wire logic pin_change_src_10,
  input wire logic pin_change_src_9,
  input wire logic [7:0] pin_change_src_23_16,
  input wire logic [7:0] converter_channels_15_8
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // pins held long enough to pass the synchroniser, inputs enabled except in s_pk_steady
  sequence s_pj_open;
    (ce && !sleep_input_disable && $stable(pj_pin_in))[*7];
  endsequence
  sequence s_pk_open;
    (ce && !sleep_input_disable && $stable(pk_pin_in))[*7];
  endsequence
  sequence s_pk_steady;
    (ce && $stable(pk_pin_in))[*7];
  endsequence
  property p_rx_dir;
    ce && serial3_rx_enable |=> pj_pin_oe_n[0];
  endproperty
  a_rx_dir: assert property (p_rx_dir) else $error("receive pin not input");
  property p_tx;
    ce && serial3_tx_enable |=> !pj_pin_oe_n[1] && !pj_pullup_en[1] && pj_pin_out[1] == $past(serial3_tx_line);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit pin not driven");
  property p_xck_out;
    ce && serial3_sync_mode |=> pj_pin_oe_n[2] || pj_pin_out[2] == $past(serial3_ext_clock);
  endproperty
  a_xck_out: assert property (p_xck_out) else $error("clock pin value wrong");
  property p_xck_in;
    ce && !serial3_sync_mode |=> !serial3_ext_clock_in;
  endproperty
  a_xck_in: assert property (p_xck_in) else $error("clock input outside sync");
  property p_pj_hi;
    s_pj_open |-> pin_change_src_15_12 == pj_pin_in[6:3];
  endproperty
  a_pj_hi: assert property (p_pj_hi) else $error("upper sources wrong");
  property p_pj_lo;
    s_pj_open |-> {pin_change_src_11, pin_change_src_10, pin_change_src_9} == pj_pin_in[2:0];
  endproperty
  a_pj_lo: assert property (p_pj_lo) else $error("lower sources wrong");
  property p_rx_line;
    s_pj_open |-> serial3_rx_line == pj_pin_in[0];
  endproperty
  a_rx_line: assert property (p_rx_line) else $error("receive line wrong");
  property p_pk_src;
    s_pk_open |-> pin_change_src_23_16 == pk_pin_in;
  endproperty
  a_pk_src: assert property (p_pk_src) else $error("second port sources wrong");
  property p_conv;
    s_pk_steady |-> converter_channels_15_8 == pk_pin_in;
  endproperty
  a_conv: assert property (p_conv) else $error("converter path wrong");
endmodule // pjk_altfn_props

bind pjk_altfn pjk_altfn_props i_props (.mclk, .nrst, .ce, .serial3_rx_enable, .serial3_tx_enable,
  .serial3_tx_line, .serial3_sync_mode, .serial3_ext_clock, .sleep_input_disable, .pj_pin_in, .pj_pin_out,
  .pj_pin_oe_n, .pj_pullup_en, .pk_pin_in, .serial3_rx_line, .serial3_ext_clock_in, .pin_change_src_15_12,
  .pin_change_src_11, .pin_change_src_10, .pin_change_src_9, .pin_change_src_23_16, .converter_channels_15_8);

// ==== tb/pjk_serial_model.sv ====
module pjk_serial_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sync_on,
  output logic tx_line,
  output logic ext_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // serial clock stands still outside synchronous mode
  always @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      tx_line <= 1'h1;
      ext_clock <= 1'h0;
    end
    else
    begin
      tx_line <= ~tx_line;
      if (sync_on)
        ext_clock <= ~ext_clock;
    end
endmodule // pjk_serial_model

// ==== tb/testbench.sv ====
`include "pjk_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, nrst, ce, reg_wr, reg_rd, serial3_rx_enable, serial3_tx_enable, serial3_sync_mode, sleep_input_disable;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, pj_pin_in, pk_pin_in;
  wire [7:0] reg_rdata, pj_pin_out, pj_pin_oe_n, pj_pullup_en, pk_pin_out, pk_pin_oe_n, pk_pullup_en;
  wire [7:0] pin_change_src_23_16, converter_channels_15_8;
  wire [3:0] pin_change_src_15_12;
  wire serial3_tx_line, serial3_ext_clock, serial3_rx_line, serial3_ext_clock_in;
  wire pin_change_src_11, pin_change_src_10, pin_change_src_9;
  int n_fail, checks, cyc;
  pjk_altfn i_dut (.mclk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial3_rx_enable,
    .serial3_tx_enable, .serial3_tx_line, .serial3_sync_mode, .serial3_ext_clock, .sleep_input_disable, .pj_pin_in,
    .pj_pin_out, .pj_pin_oe_n, .pj_pullup_en, .pk_pin_in, .pk_pin_out, .pk_pin_oe_n, .pk_pullup_en,
    .serial3_rx_line, .serial3_ext_clock_in, .pin_change_src_15_12, .pin_change_src_11, .pin_change_src_10,
    .pin_change_src_9, .pin_change_src_23_16, .converter_channels_15_8);
  pjk_serial_model i_peer (.mclk, .nrst, .sync_on(serial3_sync_mode), .tx_line(serial3_tx_line),
    .ext_clock(serial3_ext_clock));
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk("read data", reg_rdata, exp);
  endtask
  task automatic settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  initial
  begin
    {nrst, reg_wr, reg_rd, serial3_rx_enable, serial3_tx_enable, serial3_sync_mode, sleep_input_disable} = 7'h00;
    ce = 1'h1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pj_pin_in = 8'h00;
    pk_pin_in = 8'h00;
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    wr(`PJK_OFS_PORT_J, 8'hFF);
    wr(`PJK_OFS_DIR_J, 8'h0F);
    settle();
    chk("pullups", pj_pullup_en, 8'hF0);
    chk("drive", pj_pin_oe_n, 8'hF0);
    chk("port out", pj_pin_out, 8'hFF);
    wr(`PJK_OFS_CTRL, 8'h01);
    settle();
    chk("pullups off", pj_pullup_en, 8'h00);
    rd(`PJK_OFS_CTRL, 8'h01);
    rd(4'hF, 8'h00);
    // clock enable low: the write must not land
    @(posedge mclk);
    ce <= 1'h0;
    wr(`PJK_OFS_CTRL, 8'h00);
    ce <= 1'h1;
    settle();
    chk("frozen pullups", pj_pullup_en, 8'h00);
    rd(`PJK_OFS_CTRL, 8'h01);
    $display("test registers done");
    wr(`PJK_OFS_CTRL, 8'h00);
    serial3_rx_enable <= 1'h1;
    serial3_tx_enable <= 1'h1;
    serial3_sync_mode <= 1'h1;
    pj_pin_in <= 8'h04;
    settle();
    chk("serial drive", pj_pin_oe_n, 8'hF1);
    chk("serial pullups", pj_pullup_en, 8'hF1);
    chk("rx out kept", pj_pin_out & 8'hF9, 8'hF9);
    chk("clock in", {7'h00, serial3_ext_clock_in}, 8'h01);
    wr(`PJK_OFS_DIR_J, 8'h0B);
    wr(`PJK_OFS_CTRL, 8'h01);
    settle();
    chk("clock as input", pj_pin_oe_n, 8'hF5);
    chk("rx pullup off", pj_pullup_en, 8'h00);
    @(posedge mclk);
    serial3_sync_mode <= 1'h0;
    settle();
    chk("clock in idle", {7'h00, serial3_ext_clock_in}, 8'h00);
    $display("test serial done");
    @(posedge mclk);
    serial3_rx_enable <= 1'h0;
    serial3_tx_enable <= 1'h0;
    sleep_input_disable <= 1'h1;
    pj_pin_in <= 8'h5B;
    pk_pin_in <= 8'hA5;
    settle();
    chk("gated j", {1'h0, pin_change_src_15_12, pin_change_src_11, pin_change_src_10, pin_change_src_9}, 8'h00);
    chk("gated k", pin_change_src_23_16, 8'h00);
    chk("analog", converter_channels_15_8, 8'hA5);
    wr(`PJK_OFS_CTRL, 8'h06);
    wr(`PJK_OFS_MASK_J, 8'hFE);
    wr(`PJK_OFS_MASK_K, 8'h0F);
    settle();
    chk("open j", {1'h0, pin_change_src_15_12, pin_change_src_11, pin_change_src_10, pin_change_src_9}, 8'h5B);
    chk("rx line", {7'h00, serial3_rx_line}, 8'h01);
    chk("open k", pin_change_src_23_16, 8'h05);
    rd(`PJK_OFS_PIN_K, 8'h05);
    wr(`PJK_OFS_MASK_J, 8'h20);
    settle();
    chk("one pin j", {1'h0, pin_change_src_15_12, pin_change_src_11, pin_change_src_10, pin_change_src_9}, 8'h10);
    wr(`PJK_OFS_CTRL, 8'h04);
    wr(`PJK_OFS_DIR_K, 8'h0F);
    wr(`PJK_OFS_PORT_K, 8'hF0);
    settle();
    chk("group off", {4'h0, pin_change_src_15_12}, 8'h00);
    chk("k drive", pk_pin_oe_n, 8'hF0);
    chk("k out", pk_pin_out, 8'hF0);
    chk("k pullups", pk_pullup_en, 8'hF0);
    $display("test inputs done");
    report_and_stop();
  end
endmodule // testbench
